//--- rx_link_pkg.sv
// constants for the receive link-message controller: register map, field
// positions, reset values, framing and check-sequence figures
// assumes an 8-bit host register port with 16-bit addresses
package rx_link_pkg;
    // register byte addresses
    localparam logic [15:0] OBIE_ADDR  = 16'h0116;
    localparam logic [15:0] MODE_ADDR  = 16'h1100;
    localparam logic [15:0] FBIE_ADDR  = 16'h1104;
    localparam logic [15:0] CTRL_ADDR  = 16'h1118;
    localparam logic [15:0] STAT_ADDR  = 16'h1119;
    localparam logic [15:0] COUNT_ADDR = 16'h1184;
    localparam logic [15:0] INDEX_ADDR = 16'h11C0;
    localparam logic [15:0] DATA_ADDR  = 16'h11C1;
    // field positions
    localparam int MODE_E3_SEL_BIT = 6;
    localparam int MODE_FORMAT_BIT = 2;
    localparam int CTRL_ANY_BIT    = 7;
    localparam int CTRL_EN_BIT     = 2;
    localparam int CTRL_IE_BIT     = 1;
    localparam int CTRL_IS_BIT     = 0;
    localparam int OBIE_FRAMER_BIT = 2;
    localparam int FBIE_RXFR_BIT   = 7;
    // writable bits and values after reset
    localparam logic [7:0] OBIE_WMASK = 8'h0C;
    localparam logic [7:0] FBIE_WMASK = 8'hC3;
    localparam logic [7:0] CTRL_WMASK = 8'h86;
    localparam logic [7:0] REG_RESET  = 8'h00;
    // framing and check sequence
    localparam logic [7:0]  FLAG_OCTET = 8'h7E;
    localparam logic [6:0]  ABORT_ONES = 7'h7F;
    localparam logic [2:0]  STUFF_ONES = 3'h5;
    localparam logic [3:0]  FLAG_SKIP  = 4'h8;
    localparam logic [15:0] CRC_INIT   = 16'hFFFF;
    localparam logic [15:0] CRC_POLY   = 16'h8408;
    localparam logic [15:0] CRC_GOOD   = 16'hF0B8;
    // message lengths in bytes, header and check sequence included
    localparam logic [7:0] MAX_ANY_LEN   = 8'h52;
    localparam logic [7:0] STD_SHORT_LEN = 8'h52;
    localparam logic [7:0] STD_LONG_LEN  = 8'h58;
    localparam logic [7:0] MIN_MSG_LEN   = 8'h04;
    localparam logic [7:0] BUF_LIMIT     = 8'h5A;
    localparam logic [1:0] KIND_SHORT    = 2'h0;
    localparam logic [1:0] KIND_LONG     = 2'h3;
    // message buffer
    localparam int BUF_AW    = 7;
    localparam int BUF_DEPTH = 128;
endpackage : rx_link_pkg

//--- rx_msg_buffer.sv
// single-port byte memory holding the received message
// assumes one access per cycle; read data come out of a register
`timescale 1ns/1ps
`default_nettype none
module rx_msg_buffer
(
    // clock
    input  wire  logic                       clock,
    // access port
    input  wire  logic                       we,
    input  wire  logic                       re,
    input  wire  logic [rx_link_pkg::BUF_AW-1:0] addr,
    input  wire  logic [7:0]                 wdata,
    output logic [7:0]                       rdata
);
    import rx_link_pkg::*;
    logic [7:0] mem [BUF_DEPTH];

    // write wins the port; the caller never asks for both
    always_ff @(posedge clock)
    begin
        if (we)
            mem[addr] <= wdata;
        else if (re)
            rdata <= mem[addr];
    end
endmodule : rx_msg_buffer
`default_nettype wire

//--- rx_link_msg_receiver.sv
// receive link-message controller: flag hunt, bit de-stuffing, check
// sequence, message buffer and host registers
// assumes the framer hands over link bits on this clock with a bit enable
// Overview of operation
// - The controller works only when the mode register selects E3 (bit 6 low) and the G.751 format (bit 2 high).
// - The controller is active only while the enable bit 2 of the control register is one.
// - With control bit 7 set any message length from 4 to 82 bytes is taken, otherwise only the two standard sizes.
// - In any-length mode messages of up to 82 bytes are stored in the message buffer.
// - Status bit 0 shows that flag octets are being received.
// - Each completed message raises the interrupt when it is enabled.
// - Bit 2 of the operation-level enable register gates framer interrupts; bit 3 is the line block enable.
// - Bit 7 of the framer block enable register gates receive framer interrupts; bits 6, 1, 0 are stored.
// - Bit 1 of the control register enables the message interrupt at its source.
// - The status register is read-only and holds flag, end, check error, command kind, message kind, abort.
// - The byte-count register holds the size of the new message and is meaningful in any-length mode.
// - A check-sequence error raises no interrupt of its own.
// - The buffer is read indirectly: write an index, then read the data register.
`timescale 1ns/1ps
`default_nettype none
module rx_link_msg_receiver
(
    // clock and reset
    input  wire  logic        clock,
    input  wire  logic        rst_b,
    // link bits from the framer
    input  wire  logic        rx_bit,
    input  wire  logic        rx_bit_en,
    output logic              rx_ready,
    // host register port
    input  wire  logic [15:0] host_addr,
    input  wire  logic        host_wr,
    input  wire  logic        host_rd,
    input  wire  logic [7:0]  host_wdata,
    output logic [7:0]        host_rdata,
    output logic              host_rvalid,
    // interrupt to the processor
    output logic              irq
);
    import rx_link_pkg::*;

    // check-sequence step for one bit, least significant bit first
    function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
        logic [15:0] n;
        n = {1'b0, c[15:1]};
        if (c[0] ^ b)
            n = n ^ CRC_POLY;
        return n;
    endfunction : crc_bit

    // register state
    logic [7:0] obie_ff, mode_ff, fbie_ff, ctrl_ff, stat_ff, count_ff;
    logic [7:0] nxt_obie, nxt_mode, nxt_fbie, nxt_ctrl, nxt_stat, nxt_count;
    logic [BUF_AW-1:0] index_ff, nxt_index;
    logic [7:0] hold_ff, nxt_hold, rdata_ff, nxt_rdata;
    logic       pend_ff, nxt_pend, mem_sel_ff, nxt_mem_sel, rvalid_ff, irq_ff, nxt_irq;
    // receive state
    logic [7:0]  win_ff, nxt_win, asm_ff, nxt_asm, cnt_ff, nxt_cnt;
    logic [3:0]  skip_ff, nxt_skip;
    logic [2:0]  ones_ff, nxt_ones, bitc_ff, nxt_bitc;
    logic [15:0] crc_ff, nxt_crc;
    logic        frame_ff, nxt_frame, cr_ff, nxt_cr, done_ff, nxt_done;
    // buffer between receiver and memory
    logic [BUF_AW+7:0] e0_ff, e1_ff, nxt_e0, nxt_e1, push_word;
    logic [1:0]  fill_ff, nxt_fill;
    logic        push, pop, active, take_bit, host_mem_rd, good_len, is_flag;
    logic [7:0]  mem_q;

    assign active   = ctrl_ff[CTRL_EN_BIT] & ~mode_ff[MODE_E3_SEL_BIT] & mode_ff[MODE_FORMAT_BIT];
    assign rx_ready = (fill_ff != 2'h2);
    assign take_bit = rx_bit_en & rx_ready;
    assign host_mem_rd = host_rd & (host_addr == DATA_ADDR);
    assign pop = (fill_ff != 2'h0) & ~host_mem_rd;
    assign host_rdata  = rdata_ff;
    assign host_rvalid = rvalid_ff;
    assign irq = irq_ff;

    // receive path: flag window, de-stuffing, byte assembly, completion
    always_comb
    begin
        nxt_win = win_ff; nxt_asm = asm_ff; nxt_cnt = cnt_ff; nxt_skip = skip_ff;
        nxt_ones = ones_ff; nxt_bitc = bitc_ff; nxt_crc = crc_ff; nxt_frame = frame_ff;
        nxt_cr = cr_ff; nxt_done = 1'b0; nxt_stat = stat_ff; nxt_count = count_ff;
        push = 1'b0; push_word = '0; good_len = 1'b0; is_flag = 1'b0;
        if (!active)
        begin
            nxt_frame = 1'b0;
            nxt_stat[0] = 1'b0;
        end
        else if (take_bit)
        begin
            nxt_win = {rx_bit, win_ff[7:1]};
            is_flag = (nxt_win == FLAG_OCTET);
            // the oldest bit leaves the window now; when a flag closes the frame
            // it is the last check bit, so it is taken before the flag is judged
            if (skip_ff != 4'h0)
                nxt_skip = skip_ff - 4'h1;
            else if (frame_ff)
            begin
                // a zero after five ones is stuffing and is dropped
                if (ones_ff == STUFF_ONES && !win_ff[0])
                    nxt_ones = 3'h0;
                else
                begin
                    nxt_ones = win_ff[0] ? ones_ff + 3'h1 : 3'h0;
                    nxt_asm = {win_ff[0], asm_ff[7:1]};
                    nxt_crc = crc_bit(crc_ff, win_ff[0]);
                    nxt_bitc = bitc_ff + 3'h1;
                    if (bitc_ff == 3'h7)
                    begin
                        nxt_stat[0] = 1'b0;
                        push = 1'b1;
                        push_word = {cnt_ff[BUF_AW-1:0], nxt_asm};
                        if (cnt_ff == 8'h00)
                            nxt_cr = nxt_asm[1];
                        nxt_cnt = cnt_ff + 8'h01;
                        // too long for the buffer: drop until the next flag
                        if (nxt_cnt == BUF_LIMIT)
                            nxt_frame = 1'b0;
                    end
                end
            end
            if (is_flag)
            begin
                if (ctrl_ff[CTRL_ANY_BIT])
                    good_len = (nxt_cnt >= MIN_MSG_LEN) && (nxt_cnt <= MAX_ANY_LEN);
                else
                    good_len = (nxt_cnt == STD_SHORT_LEN) || (nxt_cnt == STD_LONG_LEN);
                if (frame_ff && good_len)
                begin
                    nxt_done = 1'b1;
                    nxt_count = nxt_cnt;
                    nxt_stat[1] = 1'b1;
                    nxt_stat[2] = (nxt_crc != CRC_GOOD) || (nxt_bitc != 3'h0);
                    nxt_stat[3] = nxt_cr;
                    nxt_stat[5:4] = (nxt_cnt == STD_LONG_LEN) ? KIND_LONG : KIND_SHORT;
                    nxt_stat[6] = 1'b0;
                end
                nxt_stat[0] = 1'b1;
                nxt_frame = 1'b1; nxt_cnt = 8'h00; nxt_crc = CRC_INIT;
                nxt_skip = FLAG_SKIP; nxt_bitc = 3'h0; nxt_ones = 3'h0;
            end
            else if (nxt_win[7:1] == ABORT_ONES)
            begin
                if (frame_ff && cnt_ff != 8'h00)
                    nxt_stat[6] = 1'b1;
                nxt_frame = 1'b0;
                nxt_stat[0] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            win_ff <= 8'h00; asm_ff <= 8'h00; cnt_ff <= 8'h00; skip_ff <= 4'h0;
            ones_ff <= 3'h0; bitc_ff <= 3'h0; crc_ff <= CRC_INIT; frame_ff <= 1'b0;
            cr_ff <= 1'b0; done_ff <= 1'b0; stat_ff <= REG_RESET; count_ff <= REG_RESET;
        end
        else
        begin
            win_ff <= nxt_win; asm_ff <= nxt_asm; cnt_ff <= nxt_cnt; skip_ff <= nxt_skip;
            ones_ff <= nxt_ones; bitc_ff <= nxt_bitc; crc_ff <= nxt_crc; frame_ff <= nxt_frame;
            cr_ff <= nxt_cr; done_ff <= nxt_done; stat_ff <= nxt_stat; count_ff <= nxt_count;
        end
    end

    // two-entry buffer; a host data read steals the memory port, so it stalls
    always_comb
    begin
        nxt_e0 = e0_ff; nxt_e1 = e1_ff; nxt_fill = fill_ff;
        if (push && pop)
        begin
            if (fill_ff == 2'h1)
                nxt_e0 = push_word;
            else
            begin
                nxt_e0 = e1_ff;
                nxt_e1 = push_word;
            end
        end
        else if (push)
        begin
            if (fill_ff == 2'h0)
                nxt_e0 = push_word;
            else
                nxt_e1 = push_word;
            nxt_fill = fill_ff + 2'h1;
        end
        else if (pop)
        begin
            nxt_e0 = e1_ff;
            nxt_fill = fill_ff - 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            e0_ff <= '0; e1_ff <= '0; fill_ff <= 2'h0;
        end
        else
        begin
            e0_ff <= nxt_e0; e1_ff <= nxt_e1; fill_ff <= nxt_fill;
        end
    end

    rx_msg_buffer u_buffer
    (
        .clock (clock),
        .we    (pop),
        .re    (host_mem_rd),
        .addr  (pop ? e0_ff[BUF_AW+7:8] : index_ff),
        .wdata (e0_ff[7:0]),
        .rdata (mem_q)
    );

    // host registers; reads answer two cycles after the strobe
    always_comb
    begin
        nxt_obie = obie_ff; nxt_mode = mode_ff; nxt_fbie = fbie_ff; nxt_ctrl = ctrl_ff;
        nxt_index = index_ff; nxt_hold = hold_ff; nxt_rdata = rdata_ff;
        nxt_pend = host_rd; nxt_mem_sel = host_mem_rd;
        if (host_wr)
        begin
            // status, count and bits outside each write mask ignore writes; mode takes all eight bits
            unique case (host_addr)
                OBIE_ADDR:  nxt_obie = host_wdata & OBIE_WMASK;
                MODE_ADDR:  nxt_mode = host_wdata;
                FBIE_ADDR:  nxt_fbie = host_wdata & FBIE_WMASK;
                CTRL_ADDR:  nxt_ctrl = (host_wdata & CTRL_WMASK) | {7'h00, ctrl_ff[CTRL_IS_BIT]};
                INDEX_ADDR: nxt_index = host_wdata[BUF_AW-1:0];
                default:    nxt_index = index_ff;
            endcase
        end
        if (host_rd)
        begin
            unique case (host_addr)
                OBIE_ADDR:  nxt_hold = obie_ff;
                MODE_ADDR:  nxt_hold = mode_ff;
                FBIE_ADDR:  nxt_hold = fbie_ff;
                CTRL_ADDR:  nxt_hold = ctrl_ff;
                STAT_ADDR:  nxt_hold = stat_ff;
                COUNT_ADDR: nxt_hold = count_ff;
                INDEX_ADDR: nxt_hold = {1'b0, index_ff};
                default:    nxt_hold = 8'h00;
            endcase
            if (host_addr == CTRL_ADDR)
                nxt_ctrl[CTRL_IS_BIT] = 1'b0;
        end
        // a completion in the clearing cycle still sets the bit
        if (done_ff)
            nxt_ctrl[CTRL_IS_BIT] = 1'b1;
        if (pend_ff)
            nxt_rdata = mem_sel_ff ? mem_q : hold_ff;
        // only completion feeds the status bit; check errors do not
        nxt_irq = ctrl_ff[CTRL_IS_BIT] & ctrl_ff[CTRL_IE_BIT]
                & fbie_ff[FBIE_RXFR_BIT] & obie_ff[OBIE_FRAMER_BIT];
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            obie_ff <= REG_RESET; mode_ff <= REG_RESET; fbie_ff <= REG_RESET; ctrl_ff <= REG_RESET;
            index_ff <= '0; hold_ff <= 8'h00; rdata_ff <= 8'h00; pend_ff <= 1'b0;
            mem_sel_ff <= 1'b0; rvalid_ff <= 1'b0; irq_ff <= 1'b0;
        end
        else
        begin
            obie_ff <= nxt_obie; mode_ff <= nxt_mode; fbie_ff <= nxt_fbie; ctrl_ff <= nxt_ctrl;
            index_ff <= nxt_index; hold_ff <= nxt_hold; rdata_ff <= nxt_rdata; pend_ff <= nxt_pend;
            mem_sel_ff <= nxt_mem_sel; rvalid_ff <= pend_ff; irq_ff <= nxt_irq;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence flag_taken_s;
        active && take_bit && is_flag;
    endsequence
    sequence read_strobe_s;
        host_rd && !host_wr;
    endsequence

    mode_gate_a: assert property (!mode_ff[MODE_FORMAT_BIT] |=> !frame_ff)
        else $error("frame open outside G.751 mode");
    enable_gate_a: assert property (!ctrl_ff[CTRL_EN_BIT] |=> !frame_ff && !stat_ff[0])
        else $error("receiver busy while disabled");
    std_length_a: assert property (done_ff && !ctrl_ff[CTRL_ANY_BIT]
        |-> count_ff == STD_SHORT_LEN || count_ff == STD_LONG_LEN)
        else $error("non-standard length in standard mode");
    any_length_a: assert property (done_ff && ctrl_ff[CTRL_ANY_BIT] |-> count_ff <= MAX_ANY_LEN)
        else $error("message longer than allowed");
    flag_present_a: assert property (flag_taken_s |=> stat_ff[0])
        else $error("flag not reported");
    irq_set_a: assert property (done_ff |=> ctrl_ff[CTRL_IS_BIT])
        else $error("completion not latched");
    irq_gate_a: assert property (irq |-> $past(ctrl_ff[CTRL_IE_BIT] && fbie_ff[FBIE_RXFR_BIT]
        && obie_ff[OBIE_FRAMER_BIT]))
        else $error("interrupt without all enables");
    read_clear_a: assert property ((read_strobe_s and (host_addr == CTRL_ADDR && !done_ff))
        |=> !ctrl_ff[CTRL_IS_BIT])
        else $error("status bit not cleared by read");
    read_answer_a: assert property (read_strobe_s |-> ##2 host_rvalid)
        else $error("read answer late");
    byte_count_a: assert property (done_ff |-> count_ff == $past(cnt_ff) + {7'h00, $past(push)})
        else $error("byte count wrong");
endmodule : rx_link_msg_receiver
`default_nettype wire

//--- link_peer.sv
// remote framer model: flag-delimited, bit-stuffed link messages
// assumes a bit is taken at an edge where rx_bit_en and rx_ready are both high
`timescale 1ns/1ps
`default_nettype none
module link_peer
(
    // clock
    input  wire logic clock,
    // link bits towards the receiver
    output logic      rx_bit,
    output logic      rx_bit_en,
    input  wire logic rx_ready
);
    import rx_link_pkg::*;
    int   ones;
    int   tick;
    logic pace;
    // idle line at time zero
    initial
    begin
        rx_bit    = 1'b0;
        rx_bit_en = 1'b0;
    end
    // check sequence, reflected, one byte at a time
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int k = 0; k < 8; k++)
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction : crc_step
    // bit held until an edge takes it; a slow peer idles every third bit
    task automatic put_bit(input logic b);
        logic ok;
        tick++;
        if (pace && tick % 3 == 0)
        begin
            rx_bit_en = 1'b0;
            rx_bit    = ~rx_bit;  // released line never repeats the last bit
            @(posedge clock);
            #1;
        end
        rx_bit    = b;
        rx_bit_en = 1'b1;
        ok        = 1'b0;
        while (!ok)
        begin
            @(negedge clock);
            ok = rx_ready;
            @(posedge clock);
        end
        #1;
    endtask : put_bit
    // lsb first; a zero after five ones inside the frame
    task automatic put_byte(input logic [7:0] d, input logic stuff);
        for (int i = 0; i < 8; i++)
        begin
            put_bit(d[i]);
            ones = (d[i] && stuff) ? ones + 1 : 0;
            if (ones == 5)
            begin
                put_bit(1'b0);
                ones = 0;
            end
        end
    endtask : put_byte
    // flag, bytes, check sequence, flag; an abort is eight ones after two bytes
    task automatic send_frame(input logic [7:0] m[$], input logic bad, input logic abort_it, input logic slow);
        logic [15:0] crc;
        crc  = CRC_INIT;
        ones = 0;
        pace = slow;
        put_byte(FLAG_OCTET, 1'b0);
        foreach (m[i])
        begin
            if (abort_it && i == 2)
                break;
            put_byte(m[i], 1'b1);
            crc = crc_step(crc, m[i]);
        end
        if (abort_it)
            put_byte(8'hFF, 1'b0);
        else
        begin
            crc = ~crc ^ {15'h0000, bad};
            put_byte(crc[7:0], 1'b1);
            put_byte(crc[15:8], 1'b1);
        end
        put_byte(FLAG_OCTET, 1'b0);
        rx_bit_en = 1'b0;
        rx_bit    = ~rx_bit;
    endtask : send_frame
endmodule : link_peer
`default_nettype wire

//--- tb.sv
// bench for the receive link-message controller: registers, messages, interrupt gating
// assumes link_peer drives the link side while this bench acts as the host
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rx_link_pkg::*;
    logic        clock;
    logic        rst_b       = 1'b0;
    logic        rx_bit;
    logic        rx_bit_en;
    logic        rx_ready;
    logic [15:0] host_addr   = 16'h0000;
    logic        host_wr     = 1'b0;
    logic        host_rd     = 1'b0;
    logic [7:0]  host_wdata  = 8'h00;
    logic [7:0]  host_rdata;
    logic        host_rvalid;
    logic        irq;
    int          n_fail      = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    logic [31:0] seed        = 32'h5167;
    logic [7:0]  v;
    logic [7:0]  stat        = 8'h00;
    logic [7:0]  msg[$];
    logic [15:0] addrs[7]    = '{OBIE_ADDR, MODE_ADDR, FBIE_ADDR, CTRL_ADDR, STAT_ADDR, COUNT_ADDR, 16'h1234};
    logic [7:0]  masks[7]    = '{OBIE_WMASK, 8'hFF, FBIE_WMASK, CTRL_WMASK, 8'h00, 8'h00, 8'h00};
    // mode, op enable, block enable, control, length, flags (bad, abort, random, reads, slow)
    logic [47:0] rows[16]    = '{48'h0404_8086_0410, 48'h0404_8086_5208, 48'h0404_8086_5300,
        48'h0404_8086_1e01, 48'h0404_8086_1402, 48'h0404_8006_5200, 48'h0404_8006_5810,
        48'h0404_8006_3200, 48'h0400_8086_0a00, 48'h0404_0086_0a00, 48'h0404_8084_0a00,
        48'h0404_8082_0a00, 48'h4404_8086_0a00, 48'h0004_8086_0a00, 48'h0404_8086_0004, 48'h0404_8086_0014};

    rx_link_msg_receiver dut_u (.clock(clock), .rst_b(rst_b), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
        .rx_ready(rx_ready), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .irq(irq));
    link_peer peer_u (.clock(clock), .rx_bit(rx_bit), .rx_bit_en(rx_bit_en), .rx_ready(rx_ready));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // standard sizes only, unless any length is selected
    function automatic logic accepted(input logic [7:0] c, input int len, input logic ab, input logic on);
        if (!on || ab)
            return 1'b0;
        return c[7] ? (len >= 4 && len <= 82) : (len == 82 || len == 88);
    endfunction : accepted
    function automatic logic [7:0] next_status(input logic [7:0] p, input logic ok, input logic ab, input logic on,
                                               input int len, input logic [7:0] first, input logic bad);
        if (!on)
            return {p[7:1], 1'b0};
        if (ok)
            return {2'b00, (len == 88) ? 2'b11 : 2'b00, first[1], bad, 2'b11};
        return {1'b0, p[6] | ab, p[5:1], 1'b1};
    endfunction : next_status
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one idle edge after the strobe so two tasks never touch it in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host_addr  = a;
        host_wdata = d;
        host_wr    = 1'b1;
        @(posedge clock);
        #1 host_wr = 1'b0;
        @(posedge clock);
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        host_addr = a;
        host_rd   = 1'b1;
        d         = 8'hxx;
        @(posedge clock);
        #1 host_rd = 1'b0;
        repeat (3)
        begin
            @(posedge clock);
            #1;
            if (host_rvalid === 1'b1)
                d = host_rdata;
        end
    endtask : rd
    task automatic run_row(input logic [47:0] row);
        int         len;
        logic       on;
        logic       ok;
        logic       irq_on;
        logic [7:0] rv;
        len    = row[2] ? 4 + int'(seed % 32'd79) : int'(row[15:8]);
        on     = !row[46] && row[42] && row[18];
        ok     = accepted(row[23:16], len, row[1], on);
        irq_on = ok && row[34] && row[31] && row[17];
        wr(MODE_ADDR, row[47:40]);
        wr(OBIE_ADDR, row[39:32]);
        wr(FBIE_ADDR, row[31:24]);
        wr(CTRL_ADDR, row[23:16]);
        msg.delete();
        repeat (len - 2)
        begin
            seed = lfsr(seed);
            msg.push_back(seed[7:0]);
        end
        stat = next_status(stat, ok, row[1], on, len, msg[0], row[0]);
        // data reads during receipt hold up the buffer drain
        fork
            peer_u.send_frame(msg, row[0], row[1], row[4]);
            if (row[3])
                repeat (30) rd(DATA_ADDR, rv);
        join
        repeat (4) @(posedge clock);
        #1;
        chk("irq", {7'h00, irq_on}, {7'h00, irq});
        rd(CTRL_ADDR, rv);
        chk("int status set", row[23:16] | {7'h00, ok}, rv);
        rd(CTRL_ADDR, rv);
        chk("int status clear", row[23:16], rv);
        chk("irq clear", 8'h00, {7'h00, irq});
        rd(STAT_ADDR, rv);
        chk("status", stat, rv);
        if (ok && row[23])
        begin
            rd(COUNT_ADDR, rv);
            chk("byte count", len[7:0], rv);
        end
        // header and payload only; the two check bytes are left out
        for (int i = 0; ok && i < len - 2; i++)
        begin
            wr(INDEX_ADDR, i[7:0]);
            rd(DATA_ADDR, rv);
            chk("buffer byte", msg[i], rv);
        end
    endtask : run_row
    task automatic wrap_up();
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // hang guard, well above the roughly 10k cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    // reset, register map, then the message table
    initial
    begin
        repeat (20) @(posedge clock);
        #1 rst_b = 1'b1;
        foreach (addrs[i])
        begin
            rd(addrs[i], v);
            chk("reset value", REG_RESET, v);
        end
        foreach (addrs[i])
            wr(addrs[i], 8'hFF);
        foreach (addrs[i])
        begin
            rd(addrs[i], v);
            chk("write mask", masks[i], v);
        end
        foreach (rows[r])
            run_row(rows[r]);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
